/* File: core/segmented_packet_user_port.sv */
// Segmented packet user port: transmit FIFO, link output, receive outputs, registers
`timescale 1ns/1ps

// Operation
// - Transmit ready is high while the FIFO fill level is 24 or below, out of 32 slots.
// - Ready comes from comparing the FIFO fill level with a fixed mark.
// - Overflow flag rises when user logic ignores back-pressure; users must avoid it.
// - Each enabled segment has its 128-bit data word captured, if all enabled segments of the cycle fit in free FIFO slots.
// - Each enabled segment has its 11-bit channel captured with its data, limited by extension setting.
// - All other segment signals are ignored while that segment is not enabled.
// - Error is sampled only with enable and end of packet; marks packet errored.
// - 4-bit empty count gives unused bytes of last transfer, sampled with end.
// - On errored end of packet, empty bits 2..0 are taken as zero.
// - Forced burst control with enable inserts a control word before that data.
// - Receive segment 3 exposes channel, enable, start, end, error and empty count.
// - Receive error is meaningful only with enable and end of packet high.
// - Receive empty count valid only with enable and end of packet high.
module segmented_packet_user_port
   import segmented_port_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire tx_seg_s [SEG_COUNT-1:0] tx_segment,
   input wire logic tx_channel_extension_cfg,
   output logic tx_ready,
   output logic tx_overflow,
   output link_word_s link_word,
   output logic link_valid,
   input wire logic link_ready,
   input wire rx_seg_s [SEG_COUNT-1:0] rx_link_segment,
   output logic [CHAN_W-1:0] rx_seg3_channel,
   output logic rx_seg3_enable,
   output logic rx_seg3_start_of_packet,
   output logic rx_seg3_end_of_packet,
   output logic rx_seg3_error,
   output logic [EMPTY_W-1:0] rx_seg3_empty_count,
   output logic rx_segment_error,
   output logic [EMPTY_W-1:0] rx_segment_empty_count,
   input wire reg_req_s reg_req,
   output logic [REG_W-1:0] reg_rdata,
   output logic irq
);

   typedef struct packed {
      tx_seg_s [FIFO_DEPTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [CNT_W-1:0] fill;
      logic bctl_sent;
      logic overflow;
      logic out_valid;
      link_word_s out;
      rx_seg_s rx0;
      rx_seg_s rx3;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic [REG_W-1:0] rdata;
   } port_state_s;

   port_state_s state_ff;
   port_state_s nxt_state;

   // Empty count of an errored end of packet
   function automatic logic [EMPTY_W-1:0] errored_empty(input logic [EMPTY_W-1:0] empty);
      logic [EMPTY_W-1:0] e;
      e = empty;
      e[EMPTY_LOW_W-1:0] = EMPTY_LOW_ERRORED;
      return e;
   endfunction

   // Keep only what an enabled segment may carry
   function automatic tx_seg_s clean_tx(input tx_seg_s seg, input logic ext);
      tx_seg_s c;
      c = '0;
      c.data = seg.data;
      c.channel = ext ? seg.channel : (seg.channel & SHORT_CHAN_MASK);
      c.enable = seg.enable;
      c.sop = seg.sop;
      c.eop = seg.eop;
      c.bctl = seg.bctl;
      if (seg.eop)
      begin
         c.err = seg.err;
         c.empty = seg.empty;
         if (seg.err)
         begin
            c.empty = errored_empty(seg.empty);
         end
      end
      return c;
   endfunction

   // Clear receive error and empty outside enabled end-of-packet cycles
   function automatic rx_seg_s clean_rx(input rx_seg_s seg);
      rx_seg_s c;
      c = seg;
      if (!(seg.enable && seg.eop))
      begin
         c.err = 1'b0;
         c.empty = '0;
      end
      else if (seg.err)
      begin
         c.empty = errored_empty(seg.empty);
      end
      if (!seg.enable)
      begin
         c.sop = 1'b0;
         c.eop = 1'b0;
      end
      return c;
   endfunction

   // Number of enabled segments in a cycle
   function automatic logic [NUM_W-1:0] count_enabled(input logic [SEG_COUNT-1:0] en);
      logic [NUM_W-1:0] n;
      n = '0;
      for (int i = 0; i < SEG_COUNT; i++)
      begin
         if (en[i])
         begin
            n = n + NUM_W'(1);
         end
      end
      return n;
   endfunction

   // Free FIFO slots for a fill level
   function automatic logic [CNT_W-1:0] free_slots(input logic [CNT_W-1:0] fill);
      return FIFO_DEPTH_CNT - fill;
   endfunction

   // Strobe aimed at one register offset
   function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] offset);
      return strobe && (addr == offset);
   endfunction

   // Status bits cleared by a write of ones
   function automatic logic [EV_W-1:0] clear_bits(input reg_req_s req);
      logic [EV_W-1:0] b;
      b = '0;
      if (reg_hit(req.wr, req.addr, STATUS_OFFSET))
      begin
         b = req.wdata[EV_W-1:0];
      end
      return b;
   endfunction

   // Event bits in status register layout
   function automatic logic [EV_W-1:0] event_bits(input logic ovf, input logic tx_err, input logic rx_err);
      logic [EV_W-1:0] b;
      b = '0;
      b[EV_OVERFLOW_BIT] = ovf;
      b[EV_TX_ERROR_BIT] = tx_err;
      b[EV_RX_ERROR_BIT] = rx_err;
      return b;
   endfunction

   // Control word placed ahead of a forced segment
   function automatic link_word_s control_word(input tx_seg_s seg);
      link_word_s w;
      w = '0;
      w.control = 1'b1;
      w.data = seg.data;
      w.channel = seg.channel;
      return w;
   endfunction

   // Data word carrying one stored segment
   function automatic link_word_s data_word(input tx_seg_s seg);
      link_word_s w;
      w = '0;
      w.data = seg.data;
      w.channel = seg.channel;
      w.sop = seg.sop;
      w.eop = seg.eop;
      w.err = seg.err;
      w.empty = seg.empty;
      return w;
   endfunction

   // Read word for one register offset
   function automatic logic [REG_W-1:0] read_word(input logic [ADDR_W-1:0] addr, input port_state_s s,
      input logic ready);
      logic [REG_W-1:0] w;
      w = '0;
      unique case (addr)
         STATUS_OFFSET:
         begin
            w[EV_W-1:0] = s.status;
         end
         MASK_OFFSET:
         begin
            w[EV_W-1:0] = s.mask;
         end
         FILL_OFFSET:
         begin
            w[FILL_LEVEL_LSB +: CNT_W] = s.fill;
            w[FILL_READY_BIT] = ready;
         end
         default:
         begin
            w = '0;
         end
      endcase
      return w;
   endfunction

   // Per-segment qualifiers, segment 0 earliest
   logic [SEG_COUNT-1:0] seg_enabled;
   logic [SEG_COUNT-1:0] seg_errored_end;
   for (genvar g = 0; g < SEG_COUNT; g++)
   begin : g_seg
      assign seg_enabled[g] = tx_segment[g].enable;
      assign seg_errored_end[g] = tx_segment[g].enable && tx_segment[g].eop && tx_segment[g].err;
   end

   logic [NUM_W-1:0] enabled_count;
   logic [CNT_W-1:0] free_count;
   logic accept;
   logic pop_data;
   logic tx_error_event;
   logic rx_error_event;
   logic [PTR_W-1:0] slot;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] w1c;

   always_comb
   begin
      nxt_state = state_ff;
      enabled_count = '0;
      tx_error_event = 1'b0;
      slot = state_ff.wr_ptr;
      pop_data = 1'b0;
      events = '0;
      w1c = '0;

      // Link side drain; control word goes out ahead of its data
      if (state_ff.out_valid && link_ready)
      begin
         nxt_state.out_valid = 1'b0;
      end
      if ((state_ff.fill != '0) && (!state_ff.out_valid || link_ready))
      begin
         nxt_state.out_valid = 1'b1;
         if (state_ff.mem[state_ff.rd_ptr].bctl && !state_ff.bctl_sent)
         begin
            nxt_state.out = control_word(state_ff.mem[state_ff.rd_ptr]);
            nxt_state.bctl_sent = 1'b1;
         end
         else
         begin
            nxt_state.out = data_word(state_ff.mem[state_ff.rd_ptr]);
            nxt_state.bctl_sent = 1'b0;
            nxt_state.rd_ptr = state_ff.rd_ptr + PTR_W'(1);
            pop_data = 1'b1;
         end
      end

      // Transmit capture, segment 0 first
      enabled_count = count_enabled(seg_enabled);
      free_count = free_slots(state_ff.fill);
      accept = (CNT_W'(enabled_count) <= free_count);
      nxt_state.overflow = (enabled_count != '0) && !tx_ready;
      if (accept)
      begin
         for (int i = 0; i < SEG_COUNT; i++)
         begin
            if (seg_enabled[i])
            begin
               nxt_state.mem[slot] = clean_tx(tx_segment[i], tx_channel_extension_cfg);
               slot = slot + PTR_W'(1);
            end
         end
         tx_error_event = |seg_errored_end;
         nxt_state.wr_ptr = slot;
         nxt_state.fill = state_ff.fill + CNT_W'(enabled_count) - CNT_W'(pop_data);
      end
      else
      begin
         nxt_state.fill = state_ff.fill - CNT_W'(pop_data);
      end

      // Receive outputs registered from lane side
      nxt_state.rx0 = clean_rx(rx_link_segment[0]);
      nxt_state.rx3 = clean_rx(rx_link_segment[SEG_COUNT-1]);
      rx_error_event = nxt_state.rx0.err || nxt_state.rx3.err;

      // Register writes
      w1c = clear_bits(reg_req);
      if (reg_hit(reg_req.wr, reg_req.addr, MASK_OFFSET))
      begin
         nxt_state.mask = reg_req.wdata[EV_W-1:0];
      end

      // Sticky events; a new event wins over a clear
      events = event_bits(nxt_state.overflow, tx_error_event, rx_error_event);
      nxt_state.status = (state_ff.status & ~w1c) | events;

      // Register reads, data in the next cycle only
      nxt_state.rdata = '0;
      if (reg_req.rd)
      begin
         nxt_state.rdata = read_word(reg_req.addr, state_ff, tx_ready);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_ff <= '0;
         state_ff.status <= STATUS_RESET;
         state_ff.mask <= MASK_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Back-pressure from the fill level
   assign tx_ready = (state_ff.fill <= TX_READY_LEVEL);
   assign tx_overflow = state_ff.overflow;
   assign link_word = state_ff.out;
   assign link_valid = state_ff.out_valid;
   assign rx_seg3_channel = state_ff.rx3.channel;
   assign rx_seg3_enable = state_ff.rx3.enable;
   assign rx_seg3_start_of_packet = state_ff.rx3.sop;
   assign rx_seg3_end_of_packet = state_ff.rx3.eop;
   assign rx_seg3_error = state_ff.rx3.err;
   assign rx_seg3_empty_count = state_ff.rx3.empty;
   assign rx_segment_error = state_ff.rx0.err;
   assign rx_segment_empty_count = state_ff.rx0.empty;
   assign reg_rdata = state_ff.rdata;
   assign irq = |(state_ff.status & state_ff.mask);
endmodule

/* File: inc/segmented_port_pkg.sv */
// Shared constants and carriers for the segmented packet user port
package segmented_port_pkg;
   localparam int SEG_COUNT = 4;
   localparam int DATA_W = 128;
   localparam int CHAN_W = 11;
   localparam int EMPTY_W = 4;
   localparam int FIFO_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int NUM_W = 3;
   localparam int ADDR_W = 8;
   localparam int REG_W = 32;
   localparam int EV_W = 3;

   // Ready is high while the fill level is at or below this mark
   localparam logic [CNT_W-1:0] TX_READY_LEVEL = 6'h18;
   localparam logic [CNT_W-1:0] FIFO_DEPTH_CNT = 6'h20;

   // Channel limit when channel extension is off
   localparam logic [CHAN_W-1:0] SHORT_CHAN_MASK = 11'h0ff;

   // Low empty-count bits forced on an errored end of packet
   localparam int EMPTY_LOW_W = 3;
   localparam logic [EMPTY_LOW_W-1:0] EMPTY_LOW_ERRORED = 3'h0;

   // Register offsets
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] MASK_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] FILL_OFFSET = 8'h08;

   // Status and mask bit positions
   localparam int EV_OVERFLOW_BIT = 0;
   localparam int EV_TX_ERROR_BIT = 1;
   localparam int EV_RX_ERROR_BIT = 2;

   // Fill register field positions
   localparam int FILL_LEVEL_LSB = 0;
   localparam int FILL_READY_BIT = 8;

   // Reset values
   localparam logic [EV_W-1:0] STATUS_RESET = 3'h0;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [CHAN_W-1:0] channel;
      logic enable;
      logic sop;
      logic eop;
      logic err;
      logic [EMPTY_W-1:0] empty;
      logic bctl;
   } tx_seg_s;

   typedef struct packed {
      logic [CHAN_W-1:0] channel;
      logic enable;
      logic sop;
      logic eop;
      logic err;
      logic [EMPTY_W-1:0] empty;
   } rx_seg_s;

   typedef struct packed {
      logic control;
      logic [DATA_W-1:0] data;
      logic [CHAN_W-1:0] channel;
      logic sop;
      logic eop;
      logic err;
      logic [EMPTY_W-1:0] empty;
   } link_word_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage

/* File: tb/segmented_port_props.sv */
// Pin-level checker for the segmented packet user port
`timescale 1ns/1ps
module segmented_port_checker
   import segmented_port_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire tx_seg_s [SEG_COUNT-1:0] tx_segment,
   input wire logic tx_ready,
   input wire logic tx_overflow,
   input wire link_word_s link_word,
   input wire logic link_valid,
   input wire logic link_ready,
   input wire rx_seg_s [SEG_COUNT-1:0] rx_link_segment,
   input wire logic [CHAN_W-1:0] rx_seg3_channel,
   input wire logic rx_seg3_enable,
   input wire logic rx_seg3_start_of_packet,
   input wire logic rx_seg3_end_of_packet,
   input wire logic rx_seg3_error,
   input wire logic [EMPTY_W-1:0] rx_seg3_empty_count
);
   logic viol;
   logic rx3_en;
   logic [CHAN_W-1:0] rx3_chan;
   assign viol = !tx_ready && (tx_segment[0].enable || tx_segment[1].enable ||
                               tx_segment[2].enable || tx_segment[3].enable);
   assign rx3_en = rx_link_segment[3].enable;
   assign rx3_chan = rx_link_segment[3].channel;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_ctl_taken;
      link_valid && link_ready && link_word.control;
   endsequence
   sequence s_data_next;
      link_valid && !link_word.control;
   endsequence
   a_ready_after_reset: assert property ($rose(rst_n) |-> tx_ready) else $error("ready low after reset");
   a_ovf_rise: assert property (viol |=> tx_overflow) else $error("overflow flag missing");
   a_ovf_cause: assert property (tx_overflow |-> $past(viol)) else $error("overflow without cause");
   a_link_hold: assert property (link_valid && !link_ready |=> link_valid && $stable(link_word))
      else $error("link word dropped");
   a_bctl_pair: assert property (s_ctl_taken |=> s_data_next) else $error("no data after control");
   a_link_err: assert property (link_valid && link_word.err && !link_word.control |->
      link_word.eop && link_word.empty[2:0] == 3'h0) else $error("bad errored word");
   a_rx3_copy: assert property (rx3_en |=> rx_seg3_enable && rx_seg3_channel == $past(rx3_chan))
      else $error("rx seg3 copy wrong");
   a_rx3_idle: assert property (!rx3_en |=> !rx_seg3_enable && !rx_seg3_start_of_packet)
      else $error("rx seg3 not idle");
   a_rx_err_gate: assert property (rx_seg3_error |-> rx_seg3_enable && rx_seg3_end_of_packet &&
      rx_seg3_empty_count[2:0] == 3'h0) else $error("rx error ungated");
   a_rx_empty_gate: assert property (rx_seg3_empty_count != 4'h0 |-> rx_seg3_enable && rx_seg3_end_of_packet)
      else $error("rx empty ungated");
endmodule

bind segmented_packet_user_port segmented_port_checker u_segmented_port_checker (.clock(clock),
   .rst_n(rst_n), .tx_segment(tx_segment), .tx_ready(tx_ready), .tx_overflow(tx_overflow),
   .link_word(link_word), .link_valid(link_valid), .link_ready(link_ready),
   .rx_link_segment(rx_link_segment), .rx_seg3_channel(rx_seg3_channel), .rx_seg3_enable(rx_seg3_enable),
   .rx_seg3_start_of_packet(rx_seg3_start_of_packet), .rx_seg3_end_of_packet(rx_seg3_end_of_packet),
   .rx_seg3_error(rx_seg3_error), .rx_seg3_empty_count(rx_seg3_empty_count));

/* File: tb/link_sink_model.sv */
// Lane-side sink taking link words, with stall
`timescale 1ns/1ps
module link_sink_model
   import segmented_port_pkg::*;
(
   input wire logic clock,
   input wire logic stall,
   input wire logic link_valid,
   input wire link_word_s link_word,
   output logic link_ready
);
   link_word_s got[$];
   initial link_ready = 1'b0;
   always @(posedge clock)
   begin
      if (link_valid && link_ready)
      begin
         got.push_back(link_word);
      end
      link_ready <= !stall;
   end
endmodule

/* File: tb/segmented_packet_user_port_tb.sv */
// Self-checking bench for the segmented packet user port
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module segmented_packet_user_port_tb
   import segmented_port_pkg::*;
;
   logic clock, rst_n, cfg_ext, stall, tx_ready, tx_overflow, link_valid, link_ready, irq;
   logic r3_en, r3_sop, r3_eop, r3_err, r_err;
   logic [CHAN_W-1:0] r3_chan;
   logic [EMPTY_W-1:0] r3_empty, r_empty;
   logic [REG_W-1:0] reg_rdata;
   tx_seg_s [SEG_COUNT-1:0] tx_segment;
   rx_seg_s [SEG_COUNT-1:0] rx_link_segment;
   link_word_s link_word;
   reg_req_s reg_req;
   int error_cnt, tests_run;

   segmented_packet_user_port u_segmented_packet_user_port (.clock(clock), .rst_n(rst_n),
      .tx_segment(tx_segment), .tx_channel_extension_cfg(cfg_ext), .tx_ready(tx_ready),
      .tx_overflow(tx_overflow), .link_word(link_word), .link_valid(link_valid), .link_ready(link_ready),
      .rx_link_segment(rx_link_segment), .rx_seg3_channel(r3_chan), .rx_seg3_enable(r3_en),
      .rx_seg3_start_of_packet(r3_sop), .rx_seg3_end_of_packet(r3_eop), .rx_seg3_error(r3_err),
      .rx_seg3_empty_count(r3_empty), .rx_segment_error(r_err), .rx_segment_empty_count(r_empty),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
   link_sink_model u_link_sink_model (.clock(clock), .stall(stall), .link_valid(link_valid),
      .link_word(link_word), .link_ready(link_ready));

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task close_out;
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge clock) reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock) reg_req <= '0;
   endtask

   task reg_rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
      @(posedge clock) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock) reg_req <= '0;
      #1 `CHK(reg_rdata, e)
   endtask

   // Single-transfer packets, one per enabled segment
   task send(input logic [3:0] en, input logic [3:0] bc, input logic e);
      @(posedge clock);
      for (int i = 0; i < SEG_COUNT; i++)
         tx_segment[i] <= '{128'(32'hd0 + i), 11'(11'h5a0 + i), en[i], 1'b1, 1'b1, e, 4'hf, bc[i]};
      @(posedge clock) tx_segment <= '0;
   endtask

   task wait_words(input int n);
      int k;
      for (k = 0; k < 80 && u_link_sink_model.got.size() < n; k++)
         @(posedge clock);
      if (u_link_sink_model.got.size() < n)
      begin
         error_cnt++;
         close_out();
      end
   endtask

   task t_reset;
      @(posedge clock);
      #1 `CHK(tx_ready, 1'b1)
      reg_rd(STATUS_OFFSET, 32'h0);
      reg_rd(8'h0c, 32'h0);
   endtask

   task t_bctl;
      send(4'h1, 4'h1, 1'b1);
      wait_words(2);
      `CHK(u_link_sink_model.got[0].control, 1'b1)
      `CHK(u_link_sink_model.got[0].channel, 11'h0a0)
      `CHK(u_link_sink_model.got[1].data, 128'hd0)
      `CHK(u_link_sink_model.got[1].err, 1'b1)
      `CHK(u_link_sink_model.got[1].empty, 4'h8)
      u_link_sink_model.got.delete();
      @(posedge clock) cfg_ext <= 1'b1;
      send(4'h1, 4'h0, 1'b0);
      wait_words(1);
      `CHK(u_link_sink_model.got[0].channel, 11'h5a0)
      `CHK(u_link_sink_model.got[0].empty, 4'hf)
      u_link_sink_model.got.delete();
   endtask

   task t_order;
      send(4'b1101, 4'h0, 1'b0);
      wait_words(3);
      for (int j = 0; j < 3; j++)
         `CHK(u_link_sink_model.got[j].data, 128'(32'hd0 + ((j == 0) ? 0 : j + 1)))
      u_link_sink_model.got.delete();
   endtask

   task t_overflow;
      reg_wr(STATUS_OFFSET, 32'h7);
      @(posedge clock) stall <= 1'b1;
      repeat (2) @(posedge clock);
      for (int k = 0; k < 12; k++)
      begin
         @(posedge clock) tx_segment <= '{SEG_COUNT{'{128'h1, 11'h1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0}}};
         @(negedge clock);
         if (!tx_ready)
            break;
      end
      @(posedge clock) tx_segment <= '0;
      #1 `CHK(tx_overflow, 1'b1)
      reg_rd(FILL_OFFSET, 32'h1f);
      reg_rd(STATUS_OFFSET, 32'h1);
      `CHK(irq, 1'b0)
      reg_wr(MASK_OFFSET, 32'h1);
      @(posedge clock);
      #1 `CHK(irq, 1'b1)
      reg_wr(STATUS_OFFSET, 32'h1);
      @(posedge clock);
      #1 `CHK(irq, 1'b0)
      @(posedge clock) stall <= 1'b0;
      wait_words(32);
      #1 `CHK(u_link_sink_model.got.size(), 32)
      `CHK(tx_ready, 1'b1)
      u_link_sink_model.got.delete();
   endtask

   task t_rx;
      @(posedge clock) rx_link_segment <= '{SEG_COUNT{'{11'h7ff, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf}}};
      @(posedge clock) rx_link_segment <= '{SEG_COUNT{'{11'h123, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf}}};
      #1 `CHK(r3_chan, 11'h7ff)
      `CHK({r3_en, r3_sop, r3_eop}, 3'h7)
      `CHK(r3_err, 1'b1)
      `CHK(r_err, 1'b1)
      `CHK(r3_empty, 4'h8)
      `CHK(r_empty, 4'h8)
      @(posedge clock) rx_link_segment <= '{SEG_COUNT{'{11'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf}}};
      #1 `CHK({r3_en, r3_sop, r3_eop, r3_err}, 4'h8)
      `CHK(r3_empty, 4'h0)
      `CHK(r3_chan, 11'h123)
      @(posedge clock) rx_link_segment <= '0;
      #1 `CHK({r3_en, r3_sop, r3_eop, r3_err, r_err}, 5'h0)
      `CHK(r_empty, 4'h0)
   endtask

   initial
   begin
      rst_n = 1'b0;
      cfg_ext = 1'b0;
      stall = 1'b0;
      tx_segment = '0;
      rx_link_segment = '0;
      reg_req = '0;
      error_cnt = 0;
      tests_run = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_bctl();
      t_order();
      t_overflow();
      t_rx();
      close_out();
   end
endmodule
